/* File: bod_unlock.sv */
// Timed write sequence for the brown-out sleep-off bit.
// Assumes core writes of the core control register arrive as one-cycle strobes.
`timescale 1ns/1ps
module bod_unlock
  import sleep_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Core control register write
  input wire logic wr,
  input wire logic [7:0] wdata,
  // Active sleep-off bit and open unlock window
  output logic bod_off_active,
  output logic unlock_open
);

  logic [2:0] win_r;
  logic [2:0] arm_r;
  logic [2:0] hold_r;

  // Unlock window opens on write of both bits, lasts four cycles
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      win_r <= 3'h0;
    else if (wr && wdata[CCR_BOD_OFF_BIT] && wdata[CCR_UNLOCK_BIT] && win_r == 3'h0)
      win_r <= 3'(UNLOCK_WINDOW_CYCLES);
    else if (win_r != 3'h0)
      win_r <= win_r - 3'h1;
  end

  // Set write inside window, then three cycles before the bit takes effect
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      arm_r <= 3'h0;
    else if (wr && win_r != 3'h0 && wdata[CCR_BOD_OFF_BIT] && !wdata[CCR_UNLOCK_BIT])
      arm_r <= 3'(BOD_OFF_DELAY_CYCLES);
    else if (arm_r != 3'h0)
      arm_r <= arm_r - 3'h1;
  end

  // Bit active for three cycles, then clears itself
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      hold_r <= 3'h0;
    else if (arm_r == 3'h1)
      hold_r <= 3'(BOD_OFF_HOLD_CYCLES);
    else if (hold_r != 3'h0)
      hold_r <= hold_r - 3'h1;
  end

  assign bod_off_active = (hold_r != 3'h0);
  assign unlock_open = (win_r != 3'h0);

endmodule

/* File: clk_gate.sv */
// Glitch-free clock gate cell, one per domain.
// Assumes the gated clock is the system clock; enable latched while clock low.
`timescale 1ns/1ps
module clk_gate
  import sleep_pkg::*;
(
  // Clock and enable
  input wire logic clk_in,
  input wire logic enable,
  // Gated clock
  output logic clk_out
);

  logic en_latch;

  // Latch enable during low phase so the high pulse is never cut short
  always_latch
  begin
    if (!clk_in)
    begin
      en_latch = enable;
    end
  end

  assign clk_out = clk_in & en_latch;

endmodule

/* File: core_model.sv */
// Processor core model: register writes and the sleep instruction.
// Assumes its tasks are called from the bench in the system clock domain.
`timescale 1ns/1ps
module core_model
(
  // Clock and status
  input wire logic clk,
  input wire logic core_hold,
  input wire logic bod_off,
  // Core requests
  output logic scr_wr,
  output logic [7:0] scr_wdata,
  output logic ccr_wr,
  output logic [7:0] ccr_wdata,
  output logic sleep_exec
);
  // Idle core issues nothing
  initial
  begin
    scr_wr = 1'b0;
    scr_wdata = 8'h00;
    ccr_wr = 1'b0;
    ccr_wdata = 8'h00;
    sleep_exec = 1'b0;
  end
  // One-cycle write; data inverted after, so stale values are never trusted
  task automatic write_scr(input logic [7:0] d);
    @(posedge clk);
    scr_wr <= 1'b1;
    scr_wdata <= d;
    @(posedge clk);
    scr_wr <= 1'b0;
    scr_wdata <= ~d;
  endtask
  // Arm, then execute the sleep instruction while running
  task automatic sleep_now(input logic [2:0] m, input logic arm);
    write_scr({4'h0, m, arm});
    @(posedge clk);
    sleep_exec <= !core_hold;
    @(posedge clk);
    sleep_exec <= 1'b0;
  endtask
  // Timed unlock sequence, then sleep while the sleep-off bit is live
  task automatic bod_off_sleep(input logic [2:0] m);
    write_scr({4'h0, m, 1'b1});
    @(posedge clk);
    ccr_wr <= 1'b1;
    ccr_wdata <= 8'h60;
    @(posedge clk);
    ccr_wdata <= 8'h40;
    @(posedge clk);
    ccr_wr <= 1'b0;
    ccr_wdata <= 8'h9F;
    for (int i = 0; i < 8 && bod_off !== 1'b1; i++)
      @(posedge clk);
    sleep_exec <= 1'b1;
    @(posedge clk);
    sleep_exec <= 1'b0;
  endtask
endmodule

/* File: sleep_mode_controller.sv */
// Sleep-mode controller: mode decode, clock gating, wake-up and delays.
// Assumes core signals and peripheral wake sources are on SYS_CLK; pins are synchronised here.
`timescale 1ns/1ps
module sleep_mode_controller
  import sleep_pkg::*;
#(
  parameter int STARTUP_CYCLES = 16384
)
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST,
  // Core register writes
  input wire logic SCR_WR,
  input wire logic [7:0] SCR_WDATA,
  input wire logic CCR_WR,
  input wire logic [7:0] CCR_WDATA,
  // Core sleep instruction and interrupt state
  input wire logic SLEEP_EXEC,
  input wire logic GLOBAL_IRQ_EN,
  // Peripheral configuration
  input wire logic ADC_ENABLED,
  input wire logic ASYNC_TIMER_ENABLED,
  input wire logic ASYNC_TIMER_USES_OSC,
  input wire logic ASYNC_TIMER_USES_SYNC,
  input wire logic [1:0] ASYNC_TIMER_IRQ_MASK,
  input wire logic [1:0] ASYNC_TIMER_EVENT,
  input wire logic EXT_IRQ_LEVEL_MODE,
  input wire logic BOD_FUSE_ENABLED,
  // Wake sources
  input wire wake_src_t WAKE_SRC,
  input wire logic EXT_IRQ_PIN,
  input wire logic RESET_REQ,
  // Register readback
  output logic [7:0] SCR_RDATA,
  output logic [7:0] CCR_RDATA,
  // Clock domain control
  output clk_dom_t CLK_EN,
  output logic CORE_CLK,
  output logic FLASH_CLK,
  output logic IO_CLK,
  output logic CONV_CLK,
  output logic ASYNC_CLK,
  output logic MAIN_OSC_EN,
  output logic TIMER_OSC_EN,
  // Detector and converter
  output logic BOD_EN,
  output logic ADC_START,
  // Core control
  output logic CORE_HOLD,
  output logic IRQ_DISPATCH,
  output logic RESET_VECTOR,
  output logic SLEEPING
);

  typedef enum logic [3:0] {
    ST_RUN = 4'b0001,
    ST_SLEEP = 4'b0010,
    ST_WAKE = 4'b0100,
    ST_HOLD = 4'b1000
  } state_t;

  localparam int STANDBY_CNT = STANDBY_WAKE_CYCLES;

  state_t state_r;
  state_t state_nxt;
  logic [7:0] scr_r;
  logic [2:0] mode_r;
  logic bod_off_sleep_r;
  logic reset_wake_r;
  logic [WAKE_CNT_W-1:0] wait_r;
  logic [2:0] hold_r;
  logic adc_start_r;
  logic pin_s1_r;
  logic pin_s2_r;
  logic bod_off_active;
  logic unlock_open;
  logic enter;
  logic wake_ok;
  clk_dom_t dom_en;
  logic [WAKE_CNT_W-1:0] wake_len;

  ////////////////////////////////////////////////////////////////////////////
  // Mode helpers

  // Modes allowing software detector shutdown
  function automatic logic bod_off_mode(input logic [2:0] m);
    bod_off_mode = (m == MODE_PDOWN) || (m == MODE_PSAVE) ||
                   (m == MODE_STANDBY) || (m == MODE_EXT_STANDBY);
  endfunction

  // Modes besides Idle where the asynchronous timer may keep running
  function automatic logic async_mode(input logic [2:0] m);
    async_mode = (m == MODE_ADC_NR) || (m == MODE_PSAVE) || (m == MODE_EXT_STANDBY);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Sleep control register; upper bits always zero

  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
      scr_r <= SCR_RESET;
    else if (SCR_WR)
      scr_r <= {4'h0, SCR_WDATA[3:0]};
  end

  assign SCR_RDATA = scr_r;

  // Timed write sequence for the sleep-off bit
  bod_unlock u_unlock (
    .clk(SYS_CLK),
    .rst(RST),
    .wr(CCR_WR),
    .wdata(CCR_WDATA),
    .bod_off_active(bod_off_active),
    .unlock_open(unlock_open)
  );

  // Readback shows the live sleep-off bit and unlock state
  always_comb
  begin
    CCR_RDATA = CCR_RESET;
    CCR_RDATA[CCR_BOD_OFF_BIT] = bod_off_active;
    CCR_RDATA[CCR_UNLOCK_BIT] = unlock_open;
  end

  ////////////////////////////////////////////////////////////////////////////
  // External line synchroniser; the pin is asynchronous in deep sleep

  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
    end
    else
    begin
      pin_s1_r <= EXT_IRQ_PIN;
      pin_s2_r <= pin_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Entry and wake decisions

  // Reserved codes are not entered
  assign enter = SLEEP_EXEC && scr_r[SCR_ARM_BIT] &&
                 (scr_r[3:1] != MODE_RSV4) && (scr_r[3:1] != MODE_RSV5);

  // Wake-source filter per mode
  always_comb
  begin
    logic lvl;
    logic tmr;
    lvl = WAKE_SRC.ext_level || (EXT_IRQ_LEVEL_MODE && pin_s2_r);
    tmr = ASYNC_TIMER_ENABLED && GLOBAL_IRQ_EN &&
          |(ASYNC_TIMER_IRQ_MASK & ASYNC_TIMER_EVENT);
    wake_ok = 1'b0;
    case (mode_r)
      MODE_IDLE:
        wake_ok = lvl || WAKE_SRC.ext_edge || WAKE_SRC.pin_change ||
                  WAKE_SRC.two_wire_match || WAKE_SRC.async_timer || tmr ||
                  WAKE_SRC.spm_ee_ready || WAKE_SRC.adc_done || WAKE_SRC.watchdog ||
                  WAKE_SRC.other_irq;
      MODE_ADC_NR:
        wake_ok = lvl || WAKE_SRC.pin_change || WAKE_SRC.two_wire_match ||
                  (ASYNC_TIMER_USES_OSC && tmr) || WAKE_SRC.spm_ee_ready ||
                  WAKE_SRC.adc_done || WAKE_SRC.watchdog;
      MODE_PSAVE, MODE_EXT_STANDBY:
        wake_ok = lvl || WAKE_SRC.pin_change || WAKE_SRC.two_wire_match ||
                  tmr || WAKE_SRC.watchdog;
      default:
        wake_ok = lvl || WAKE_SRC.pin_change || WAKE_SRC.two_wire_match ||
                  WAKE_SRC.watchdog;
    endcase
  end

  // Wake delay per mode; a detector turned off raises it to at least its settle time
  always_comb
  begin
    wake_len = WAKE_CNT_W'(1);
    if (mode_r == MODE_STANDBY || mode_r == MODE_EXT_STANDBY)
      wake_len = WAKE_CNT_W'(STANDBY_CNT);
    else if (mode_r == MODE_PDOWN || mode_r == MODE_PSAVE)
      wake_len = WAKE_CNT_W'(STARTUP_CYCLES);
    if (bod_off_sleep_r && wake_len < WAKE_CNT_W'(BOD_WAKE_CYCLES))
      wake_len = WAKE_CNT_W'(BOD_WAKE_CYCLES);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State machine

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN:
        if (enter)
          state_nxt = ST_SLEEP;
      ST_SLEEP:
        if (RESET_REQ || wake_ok)
          state_nxt = ST_WAKE;
      ST_WAKE:
        if (wait_r <= WAKE_CNT_W'(1))
          state_nxt = reset_wake_r ? ST_RUN : ST_HOLD;
      ST_HOLD:
        if (hold_r == 3'h1)
          state_nxt = ST_RUN;
      default:
        state_nxt = ST_RUN;
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
      state_r <= ST_RUN;
    else
      state_r <= state_nxt;
  end

  // Mode and detector choice captured at entry
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      mode_r <= MODE_IDLE;
      bod_off_sleep_r <= 1'b0;
    end
    else if (state_r == ST_RUN && enter)
    begin
      mode_r <= scr_r[3:1];
      bod_off_sleep_r <= bod_off_active && bod_off_mode(scr_r[3:1]);
    end
    else if (state_r == ST_WAKE && state_nxt != ST_WAKE)
      bod_off_sleep_r <= 1'b0;
  end

  // Wake reason: reset or interrupt
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
      reset_wake_r <= 1'b0;
    else if (state_r == ST_SLEEP && (RESET_REQ || wake_ok))
      reset_wake_r <= RESET_REQ;
  end

  // Start-up counter
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
      wait_r <= '0;
    else if (state_r == ST_SLEEP)
      wait_r <= wake_len;
    else if (state_r == ST_WAKE && wait_r != '0)
      wait_r <= wait_r - WAKE_CNT_W'(1);
  end

  // Extra hold before the interrupt handler runs
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
      hold_r <= 3'h0;
    else if (state_r == ST_WAKE)
      hold_r <= 3'(IRQ_HOLD_CYCLES);
    else if (state_r == ST_HOLD && hold_r != 3'h0)
      hold_r <= hold_r - 3'h1;
  end

  // Conversion start pulse on entry to Idle or ADC noise
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
      adc_start_r <= 1'b0;
    else
      adc_start_r <= (state_r == ST_RUN) && enter && ADC_ENABLED &&
                     (scr_r[3:1] == MODE_IDLE || scr_r[3:1] == MODE_ADC_NR);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Domain enables; wake restores every domain together

  always_comb
  begin
    dom_en = '{core: 1'b1, flash: 1'b1, io: 1'b1, conv: 1'b1, async: 1'b1};
    if (state_r == ST_SLEEP)
    begin
      dom_en.core = 1'b0;
      dom_en.flash = 1'b0;
      case (mode_r)
        MODE_IDLE:
          dom_en.io = 1'b1;
        MODE_ADC_NR:
        begin
          dom_en.io = 1'b0;
          dom_en.async = ASYNC_TIMER_USES_OSC;
        end
        default:
        begin
          dom_en.io = 1'b0;
          dom_en.conv = 1'b0;
          dom_en.async = async_mode(mode_r) && ASYNC_TIMER_ENABLED &&
                         (ASYNC_TIMER_USES_OSC || ASYNC_TIMER_USES_SYNC);
        end
      endcase
    end
  end

  assign CLK_EN = dom_en;

  // Glitch-free gating for each domain
  clk_gate u_core (.clk_in(SYS_CLK), .enable(dom_en.core), .clk_out(CORE_CLK));
  clk_gate u_flash (.clk_in(SYS_CLK), .enable(dom_en.flash), .clk_out(FLASH_CLK));
  clk_gate u_io (.clk_in(SYS_CLK), .enable(dom_en.io), .clk_out(IO_CLK));
  clk_gate u_conv (.clk_in(SYS_CLK), .enable(dom_en.conv), .clk_out(CONV_CLK));
  clk_gate u_async (.clk_in(SYS_CLK), .enable(dom_en.async), .clk_out(ASYNC_CLK));

  // Oscillators: main kept in shallow and standby modes
  always_comb
  begin
    MAIN_OSC_EN = 1'b1;
    TIMER_OSC_EN = ASYNC_TIMER_USES_OSC;
    if (state_r == ST_SLEEP)
    begin
      if (mode_r == MODE_PDOWN)
        MAIN_OSC_EN = 1'b0;
      else if (mode_r == MODE_PSAVE)
        MAIN_OSC_EN = ASYNC_TIMER_ENABLED && ASYNC_TIMER_USES_SYNC;
      if (!(async_mode(mode_r) && ASYNC_TIMER_ENABLED) && mode_r != MODE_IDLE)
        TIMER_OSC_EN = 1'b0;
    end
  end

  // Detector on when its fuse enables it, unless off by software during sleep
  assign BOD_EN = BOD_FUSE_ENABLED && !(state_r == ST_SLEEP && bod_off_sleep_r);

  ////////////////////////////////////////////////////////////////////////////
  // Core-facing outputs; memory is not touched, only its clock stops

  assign ADC_START = adc_start_r;
  assign CORE_HOLD = (state_r != ST_RUN);
  assign IRQ_DISPATCH = (state_r == ST_HOLD) && (hold_r == 3'h1);
  assign RESET_VECTOR = (state_r == ST_WAKE) && reset_wake_r && (state_nxt == ST_RUN);
  assign SLEEPING = (state_r == ST_SLEEP);

endmodule

/* File: sleep_mode_controller_asserts.sv */
// Port checker for the sleep-mode controller.
// Assumes one clock domain and an active-high asynchronous reset.
`timescale 1ns/1ps
module sleep_mode_controller_asserts
  import sleep_pkg::*;
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST,
  // Watched inputs
  input wire logic SLEEP_EXEC,
  input wire logic ADC_ENABLED,
  input wire logic BOD_FUSE_ENABLED,
  input wire logic RESET_REQ,
  // Watched outputs
  input wire logic [7:0] SCR_RDATA,
  input wire clk_dom_t CLK_EN,
  input wire logic MAIN_OSC_EN,
  input wire logic BOD_EN,
  input wire logic ADC_START,
  input wire logic CORE_HOLD,
  input wire logic IRQ_DISPATCH,
  input wire logic RESET_VECTOR,
  input wire logic SLEEPING
);
  default clocking @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);
  logic [2:0] mode;
  logic ok;
  logic shallow;
  // Mode comes from readback, since the core is halted while asleep
  assign mode = SCR_RDATA[3:1];
  assign ok = SCR_RDATA[0] && (mode != MODE_RSV4) && (mode != MODE_RSV5);
  assign shallow = (mode == MODE_IDLE) || (mode == MODE_ADC_NR);
  //////////////////////////////////////////////////////////////////////////
  a_sleep_entry: assert property (SLEEP_EXEC && !CORE_HOLD && ok |=> SLEEPING)
    else $error("sleep not entered");
  a_sleep_refused: assert property (SLEEP_EXEC && !CORE_HOLD && !ok |=> !SLEEPING)
    else $error("sleep entered while refused");
  a_upper_zero: assert property (SCR_RDATA[7:4] == 4'h0)
    else $error("upper sleep control bits set");
  a_idle_domains: assert property (SLEEPING && mode == MODE_IDLE |->
    !CLK_EN.core && !CLK_EN.flash && CLK_EN.io && CLK_EN.conv)
    else $error("idle domains wrong");
  a_noise_domains: assert property (SLEEPING && mode == MODE_ADC_NR |->
    !CLK_EN.core && !CLK_EN.flash && !CLK_EN.io && CLK_EN.conv)
    else $error("noise reduction domains wrong");
  a_pdown_stop: assert property (SLEEPING && mode == MODE_PDOWN |->
    CLK_EN == 5'h00 && !MAIN_OSC_EN)
    else $error("power-down clocks running");
  a_standby_osc: assert property (SLEEPING && mode == MODE_STANDBY |->
    CLK_EN == 5'h00 && MAIN_OSC_EN)
    else $error("standby oscillator wrong");
  a_bod_kept: assert property (SLEEPING && shallow |-> BOD_EN == BOD_FUSE_ENABLED)
    else $error("detector off in shallow mode");
  a_conv_start: assert property ($rose(SLEEPING) && shallow && ADC_ENABLED |-> ADC_START)
    else $error("conversion not started");
  a_bod_restore: assert property (!SLEEPING && !CORE_HOLD |-> BOD_EN == BOD_FUSE_ENABLED)
    else $error("detector not back on");
  a_dispatch_hold: assert property (IRQ_DISPATCH |->
    CORE_HOLD && !SLEEPING && $past(CORE_HOLD, 3) ##1 !CORE_HOLD)
    else $error("hold before handler wrong");
  // Reset wake from power-down or power-save waits out the full start-up count, far beyond a delay range, so count it here
  localparam logic [15:0] RESET_WAKE_LIMIT = 16'h4268;
  logic rst_wait_r;
  logic [15:0] rst_cnt_r;
  // Pending from a reset request while asleep until the reset vector is taken
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
      rst_wait_r <= 1'b0;
    else if (RESET_VECTOR)
      rst_wait_r <= 1'b0;
    else if (SLEEPING && RESET_REQ)
      rst_wait_r <= 1'b1;
  end
  // Cycles spent waiting; cleared whenever nothing is pending
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
      rst_cnt_r <= 16'h0000;
    else if (!rst_wait_r)
      rst_cnt_r <= 16'h0000;
    else
      rst_cnt_r <= rst_cnt_r + 16'h0001;
  end
  a_reset_wake: assert property (rst_wait_r |-> rst_cnt_r < RESET_WAKE_LIMIT)
    else $error("reset did not wake");
endmodule
bind sleep_mode_controller sleep_mode_controller_asserts chk (
  .SYS_CLK(SYS_CLK), .RST(RST), .SLEEP_EXEC(SLEEP_EXEC), .ADC_ENABLED(ADC_ENABLED),
  .BOD_FUSE_ENABLED(BOD_FUSE_ENABLED), .RESET_REQ(RESET_REQ), .SCR_RDATA(SCR_RDATA),
  .CLK_EN(CLK_EN), .MAIN_OSC_EN(MAIN_OSC_EN), .BOD_EN(BOD_EN), .ADC_START(ADC_START),
  .CORE_HOLD(CORE_HOLD), .IRQ_DISPATCH(IRQ_DISPATCH), .RESET_VECTOR(RESET_VECTOR),
  .SLEEPING(SLEEPING)
);

/* File: sleep_mode_controller_bench.sv */
// Self-checking bench for the sleep-mode controller.
// Assumes the core model and the bound port checker are compiled alongside.
`timescale 1ns/1ps
module sleep_mode_controller_bench;
  import sleep_pkg::*;
  localparam int SU = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic gie = 1'b1;
  logic adc_en = 1'b1;
  logic tmr_en = 1'b1;
  logic tmr_osc = 1'b1;
  logic [1:0] tmr_mask = 2'h1;
  logic [1:0] tmr_evt = 2'h0;
  logic lvl_mode = 1'b0;
  logic pin = 1'b0;
  logic rst_req = 1'b0;
  wake_src_t src = '0;
  logic scr_wr, ccr_wr, sleep_exec, osc_en, tosc_en, bod_en, adc_start;
  logic hold, disp, rvec, sleeping;
  logic core_clk, flash_clk, io_clk, conv_clk, async_clk;
  logic [7:0] scr_wd, ccr_wd, scr_rd, ccr_rd;
  clk_dom_t clk_en;
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  // 25 MHz system clock
  initial
  begin
    forever #20 clk = ~clk;
  end
  core_model core (.clk(clk), .core_hold(hold), .bod_off(ccr_rd[6]), .scr_wr(scr_wr),
    .scr_wdata(scr_wd), .ccr_wr(ccr_wr), .ccr_wdata(ccr_wd), .sleep_exec(sleep_exec));
  // Short start-up count keeps the deep-mode wakes brief
  sleep_mode_controller #(.STARTUP_CYCLES(SU)) dut (.SYS_CLK(clk), .RST(rst),
    .SCR_WR(scr_wr), .SCR_WDATA(scr_wd), .CCR_WR(ccr_wr), .CCR_WDATA(ccr_wd),
    .SLEEP_EXEC(sleep_exec), .GLOBAL_IRQ_EN(gie), .ADC_ENABLED(adc_en),
    .ASYNC_TIMER_ENABLED(tmr_en), .ASYNC_TIMER_USES_OSC(tmr_osc),
    .ASYNC_TIMER_USES_SYNC(1'b0), .ASYNC_TIMER_IRQ_MASK(tmr_mask),
    .ASYNC_TIMER_EVENT(tmr_evt), .EXT_IRQ_LEVEL_MODE(lvl_mode), .BOD_FUSE_ENABLED(1'b1),
    .WAKE_SRC(src), .EXT_IRQ_PIN(pin), .RESET_REQ(rst_req), .SCR_RDATA(scr_rd),
    .CCR_RDATA(ccr_rd), .CLK_EN(clk_en), .CORE_CLK(core_clk), .FLASH_CLK(flash_clk),
    .IO_CLK(io_clk), .CONV_CLK(conv_clk), .ASYNC_CLK(async_clk),
    .MAIN_OSC_EN(osc_en), .TIMER_OSC_EN(tosc_en),
    .BOD_EN(bod_en), .ADC_START(adc_start), .CORE_HOLD(hold), .IRQ_DISPATCH(disp),
    .RESET_VECTOR(rvec), .SLEEPING(sleeping));
  //////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic complete_run();
    if (err_total == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Compare tasks, one per kind of result
  task automatic check_val(input logic [7:0] got, input logic [7:0] exp, input string m);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic check_range(input int got, input int lo, input int hi, input string m);
    total_checks++;
    if (got < lo || got > hi)
    begin
      err_total++;
      $display("wrong value at %0t: %s %0d", $time, m, got);
    end
  endtask
  // Bounded wait for either end of a wake-up
  task automatic wait_wake(output int n);
    n = 0;
    while (n < 3000 && disp !== 1'b1 && rvec !== 1'b1)
    begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  // Sleep, show ignored sources, then a real source
  task automatic t_ignored(input logic [2:0] m, input wake_src_t bad, input wake_src_t good);
    int n;
    core.sleep_now(m, 1'b1);
    src <= bad;
    repeat (20) @(posedge clk);
    #1 check_val(sleeping, 1'b1, "woke on ignored source");
    // Clock is high here, so a running domain shows high and a stopped one low
    check_val({core_clk, flash_clk, io_clk, conv_clk, async_clk},
      {3'h0, {2{m == MODE_ADC_NR}}}, "gated clocks wrong");
    src <= good;
    wait_wake(n);
    check_val(disp, 1'b1, "listed source did not wake");
    src <= '0;
  endtask
  // Every valid mode enters and wakes with its own delay
  task automatic t_modes();
    logic [2:0] md[6] = '{MODE_IDLE, MODE_ADC_NR, MODE_PDOWN, MODE_PSAVE, MODE_STANDBY,
      MODE_EXT_STANDBY};
    int len[6] = '{1, 1, SU, SU, STANDBY_WAKE_CYCLES, STANDBY_WAKE_CYCLES};
    int n;
    for (int i = 0; i < 6; i++)
    begin
      core.sleep_now(md[i], 1'b1);
      #1 check_val(sleeping, 1'b1, "mode not entered");
      src.watchdog <= 1'b1;
      wait_wake(n);
      check_range(n, len[i] + 4, len[i] + 7, "wake delay");
      src <= '0;
      @(posedge clk);
      #1 check_val(clk_en, 5'h1F, "domains not restored");
    end
  endtask
  // Refusals, then unlock sequence and detector-off wake
  task automatic t_regs_bod();
    int n;
    core.write_scr(8'hFF);
    #1 check_val(scr_rd, 8'h0F, "upper bits not zero");
    core.sleep_now(MODE_IDLE, 1'b0);
    #1 check_val(sleeping, 1'b0, "unarmed sleep");
    core.sleep_now(MODE_RSV4, 1'b1);
    #1 check_val(sleeping, 1'b0, "reserved code 100 slept");
    core.sleep_now(MODE_RSV5, 1'b1);
    #1 check_val(sleeping, 1'b0, "reserved code 101 slept");
    core.bod_off_sleep(MODE_PDOWN);
    #1 check_val(bod_en, 1'b0, "detector still on");
    src.two_wire_match <= 1'b1;
    wait_wake(n);
    check_range(n, BOD_WAKE_CYCLES, BOD_WAKE_CYCLES + 30, "stretched wake");
    src <= '0;
    @(posedge clk);
    #1 check_val(bod_en, 1'b1, "detector not re-enabled");
  endtask
  // Timer wake in power-save, level pin wake, reset wake
  task automatic t_timer_pin_reset();
    int n;
    gie <= 1'b0;
    core.sleep_now(MODE_PSAVE, 1'b1);
    tmr_evt <= 2'h1;
    repeat (20) @(posedge clk);
    #1 check_val(sleeping, 1'b1, "timer woke with interrupts off");
    check_val(tosc_en, 1'b1, "timer oscillator stopped");
    check_val(osc_en, 1'b0, "main clock kept in power-save");
    gie <= 1'b1;
    wait_wake(n);
    check_val(disp, 1'b1, "timer did not wake");
    tmr_evt <= 2'h0;
    lvl_mode <= 1'b1;
    core.sleep_now(MODE_PDOWN, 1'b1);
    pin <= 1'b1;
    wait_wake(n);
    check_val(disp, 1'b1, "level pin did not wake");
    pin <= 1'b0;
    core.sleep_now(MODE_PDOWN, 1'b1);
    rst_req <= 1'b1;
    wait_wake(n);
    check_val({rvec, disp}, 2'h2, "reset wake path");
    rst_req <= 1'b0;
  endtask
  // Cuts a hang short
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      complete_run();
    end
  end
  // Main sequence
  initial
  begin
    wake_src_t bad;
    wake_src_t good;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1 check_val(scr_rd, SCR_RESET, "sleep control reset");
    check_val(ccr_rd, CCR_RESET, "sleep-off bit reset");
    t_modes();
    bad = '0;
    good = '0;
    bad.ext_edge = 1'b1;
    bad.other_irq = 1'b1;
    good.pin_change = 1'b1;
    t_ignored(MODE_PDOWN, bad, good);
    bad.ext_edge = 1'b0;
    good = '0;
    good.adc_done = 1'b1;
    t_ignored(MODE_ADC_NR, bad, good);
    t_regs_bod();
    t_timer_pin_reset();
    complete_run();
  end
endmodule

/* File: sleep_pkg.sv */
// Shared constants and types for the sleep-mode controller.
// Assumes a single 25 MHz system clock domain.
package sleep_pkg;

  // Sleep mode select encodings
  localparam logic [2:0] MODE_IDLE = 3'h0;
  localparam logic [2:0] MODE_ADC_NR = 3'h1;
  localparam logic [2:0] MODE_PDOWN = 3'h2;
  localparam logic [2:0] MODE_PSAVE = 3'h3;
  localparam logic [2:0] MODE_RSV4 = 3'h4;
  localparam logic [2:0] MODE_RSV5 = 3'h5;
  localparam logic [2:0] MODE_STANDBY = 3'h6;
  localparam logic [2:0] MODE_EXT_STANDBY = 3'h7;

  // Register field positions
  localparam int SCR_ARM_BIT = 0;
  localparam int SCR_MODE_LSB = 1;
  localparam int CCR_BOD_OFF_BIT = 6;
  localparam int CCR_UNLOCK_BIT = 5;
  localparam logic [7:0] SCR_RESET = 8'h00;
  localparam logic [7:0] CCR_RESET = 8'h00;

  // Timing
  localparam int CLK_MHZ = 25;
  localparam int CLK_PERIOD_NS = 40;
  localparam int IRQ_HOLD_CYCLES = 4;
  localparam int STANDBY_WAKE_CYCLES = 6;
  localparam int BOD_WAKE_US = 60;
  localparam int BOD_WAKE_CYCLES = BOD_WAKE_US * 1000 / CLK_PERIOD_NS;
  localparam int UNLOCK_WINDOW_CYCLES = 4;
  localparam int BOD_OFF_DELAY_CYCLES = 3;
  localparam int BOD_OFF_HOLD_CYCLES = 3;
  localparam int WAKE_CNT_W = 16;

  // Clock domain enables
  typedef struct packed {
    logic core;
    logic flash;
    logic io;
    logic conv;
    logic async;
  } clk_dom_t;

  // Wake-up sources offered by the peripherals
  typedef struct packed {
    logic ext_level;
    logic ext_edge;
    logic pin_change;
    logic two_wire_match;
    logic async_timer;
    logic spm_ee_ready;
    logic adc_done;
    logic watchdog;
    logic other_irq;
  } wake_src_t;

endpackage
